/* shared/pmlt_pkg.sv */
// Constants, modes and states of the MAC-side latency and timing block
// How it works
// - 100 Mb/s: start code leaves about 6 bit times after first TX_CLK rise
// - 100 Mb/s: end code leaves about 6 bit times after first rise past TX_EN
// - 100 Mb/s: carrier sense on after 20 bits; receive data 24 bits late
// - 100 Mb/s: carrier sense off 24 bit times after the end code
// - 10 Mb/s MII: TX_CLK 200 ns high and low; inputs sampled on its fall
// - 10 Mb/s: media output 3.5 bit times after the transmit sampling edge
// - Serial mode: TX_CLK 25 ns high, 75 ns low; inputs taken on its rise
// - Serial mode: RX_CLK 50 ns phases; receive outputs change on its fall
// - 10 Mb/s MII: receive outputs settle well before and after RX_CLK edges
// - 10BASE-T: carrier sense typically 630 ns, at most 1000 ns after activity
// - 10BASE-T: RX_DV about 10 bit times after the first preamble bit
// - 10BASE-T: carrier sense off within 1.0 us after the packet ends
// - 10 Mb/s: heartbeat on COL within 1200 ns of TX_EN fall, 1000 ns long
// - 10 Mb/s: jabber after 85 ms of transmission, released after 500 ms
// - RX_CLK phases may stretch on clock switching but never shorten
package pmlt_pkg;

  typedef enum logic [1:0] {
    PMLT_M100   = 2'b00,
    PMLT_M10MII = 2'b01,
    PMLT_M10SER = 2'b10
  } pmlt_mode_e;

  typedef enum logic [1:0] {
    PMLT_RX_IDLE = 2'b00,
    PMLT_RX_ON   = 2'b01,
    PMLT_RX_ACT  = 2'b10,
    PMLT_RX_OFF  = 2'b11
  } pmlt_rx_e;

  typedef enum logic [1:0] {
    PMLT_HB_IDLE = 2'b00,
    PMLT_HB_WAIT = 2'b01,
    PMLT_HB_ON   = 2'b10
  } pmlt_hb_e;

  localparam int PMLT_CLK_NS = 40;

  // Least times round up, longest and typical times round down, never below one cycle
  function automatic int pmlt_cyc_min(input int ns);
    int c;
    c = (ns + PMLT_CLK_NS - 1) / PMLT_CLK_NS;
    return (c < 1) ? 1 : c;
  endfunction

  function automatic int pmlt_cyc_max(input int ns);
    int c;
    c = ns / PMLT_CLK_NS;
    return (c < 1) ? 1 : c;
  endfunction

  localparam int PMLT_BIT100_NS = 10;
  localparam int PMLT_BIT10_NS = 100;

  localparam int PMLT_TXCLK100_NS = 20;
  localparam int PMLT_TXCLK10_NS = 200;
  localparam int PMLT_TXSER_HI_NS = 25;
  localparam int PMLT_TXSER_LO_NS = 75;
  localparam int PMLT_RXCLK10_NS = 200;
  localparam int PMLT_RXSER_NS = 50;

  localparam int PMLT_TX100_LAT_NS = 6 * PMLT_BIT100_NS;
  localparam int PMLT_TX10_LAT_NS = 35 * PMLT_BIT10_NS / 10;
  localparam int PMLT_CRS_ON100_NS = 20 * PMLT_BIT100_NS;
  localparam int PMLT_RX100_LAT_NS = 24 * PMLT_BIT100_NS;
  localparam int PMLT_CRS_OFF100_NS = 24 * PMLT_BIT100_NS;
  localparam int PMLT_CRS_ON10_NS = 630;
  localparam int PMLT_RXDV10_NS = 10 * PMLT_BIT10_NS;
  localparam int PMLT_CRS_OFF10_NS = 1000;
  localparam int PMLT_HB_DLY_NS = 1200;
  localparam int PMLT_HB_ON_NS = 1000;
  localparam int PMLT_JAB_ON_MS = 85;
  localparam int PMLT_JAB_OFF_MS = 500;

  localparam int PMLT_TXCLK100_CYC = pmlt_cyc_min(PMLT_TXCLK100_NS);
  localparam int PMLT_TXCLK10_CYC = pmlt_cyc_min(PMLT_TXCLK10_NS);
  localparam int PMLT_TXSER_HI_CYC = pmlt_cyc_min(PMLT_TXSER_HI_NS);
  localparam int PMLT_TXSER_LO_CYC = pmlt_cyc_min(PMLT_TXSER_LO_NS);
  localparam int PMLT_RXCLK10_CYC = pmlt_cyc_min(PMLT_RXCLK10_NS);
  localparam int PMLT_RXSER_CYC = pmlt_cyc_max(PMLT_RXSER_NS);

  localparam int PMLT_TX100_LAT_CYC = pmlt_cyc_max(PMLT_TX100_LAT_NS);
  localparam int PMLT_TX10_LAT_CYC = pmlt_cyc_max(PMLT_TX10_LAT_NS);
  localparam int PMLT_CRS_ON100_CYC = pmlt_cyc_max(PMLT_CRS_ON100_NS);
  localparam int PMLT_RX100_LAT_CYC = pmlt_cyc_max(PMLT_RX100_LAT_NS);
  localparam int PMLT_CRS_OFF100_CYC = pmlt_cyc_max(PMLT_CRS_OFF100_NS);
  localparam int PMLT_CRS_ON10_CYC = pmlt_cyc_max(PMLT_CRS_ON10_NS);
  localparam int PMLT_RXDV10_CYC = pmlt_cyc_max(PMLT_RXDV10_NS);
  localparam int PMLT_CRS_OFF10_CYC = pmlt_cyc_max(PMLT_CRS_OFF10_NS);
  localparam int PMLT_HB_DLY_CYC = pmlt_cyc_max(PMLT_HB_DLY_NS);
  localparam int PMLT_HB_ON_CYC = pmlt_cyc_max(PMLT_HB_ON_NS);
  localparam int PMLT_JAB_ON_CYC = PMLT_JAB_ON_MS * 1000000 / PMLT_CLK_NS;
  localparam int PMLT_JAB_OFF_CYC = PMLT_JAB_OFF_MS * 1000000 / PMLT_CLK_NS;

  localparam int PMLT_LINE_QUAL_CYC = 2;
  localparam int PMLT_DLY_DEPTH = 32;

  // Worst-case activity crossing (line sync, qualify, two clk flops) comes off the
  // 10 Mb/s carrier-off hold, so crs still drops within 1 us of the media going quiet
  localparam int PMLT_CRS_SYNC_CYC = 4;
  localparam int PMLT_CRS_OFF10_LD_CYC = PMLT_CRS_OFF10_CYC - PMLT_CRS_SYNC_CYC;

endpackage

/* verilog/pmlt_delay.sv */
// Tapped delay line for the transmit and receive latency paths
`timescale 1ns/1ps
module pmlt_delay #(
  parameter int WIDTH = 7,
  parameter int DEPTH = 32
) (
  input wire logic clk, // System clock
  input wire logic rst_n, // Synchronised reset, active low
  input wire logic [$clog2(DEPTH)-1:0] sel, // Tap index, delay is sel+1 cycles
  input wire logic [WIDTH-1:0] din, // Word entering the line
  output logic [WIDTH-1:0] dout // Word at the selected tap
);
  logic [WIDTH-1:0] stage_reg [DEPTH];

  genvar i;
  generate
    for (i = 0; i < DEPTH; i++) begin : g_stage
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          stage_reg[i] <= '0;
        end else begin
          stage_reg[i] <= (i == 0) ? din : stage_reg[(i == 0) ? 0 : i - 1];
        end
      end
    end
  endgenerate

  assign dout = stage_reg[sel];
endmodule // pmlt_delay

/* verilog/pmlt_clkgen.sv */
// Divider that makes an interface clock with programmable high and low phases
`timescale 1ns/1ps
module pmlt_clkgen (
  input wire logic clk, // System clock
  input wire logic rst_n, // Synchronised reset, active low
  input wire logic [4:0] hi_len, // High phase length in cycles, at least one
  input wire logic [4:0] lo_len, // Low phase length in cycles, at least one
  output logic clk_out, // Generated clock, from a flip-flop
  output logic rise_next, // Clock goes high at the coming edge
  output logic fall_next // Clock goes low at the coming edge
);
  logic [4:0] cnt_reg;

  // A phase length is taken only when the phase starts, so a length change
  // can stretch a phase but never cut one short
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      clk_out <= 1'b0;
      cnt_reg <= 5'h00;
    end else if (cnt_reg == 5'h00) begin
      clk_out <= !clk_out;
      cnt_reg <= clk_out ? lo_len - 5'h01 : hi_len - 5'h01;
    end else begin
      cnt_reg <= cnt_reg - 5'h01;
    end
  end

  assign rise_next = (cnt_reg == 5'h00) && !clk_out;
  assign fall_next = (cnt_reg == 5'h00) && clk_out;
endmodule // pmlt_clkgen

/* verilog/pmlt_top.sv */
// MAC-side timing and latency core of a 10/100 transceiver
`timescale 1ns/1ps
module pmlt_top #(
  parameter int JAB_ON_CYC = pmlt_pkg::PMLT_JAB_ON_CYC, // Transmit time before jabber
  parameter int JAB_OFF_CYC = pmlt_pkg::PMLT_JAB_OFF_CYC // Jabber hold time
) (
  input wire logic clk, // System clock, 25 MHz
  input wire logic rst_b, // Asynchronous reset, active low
  input wire logic line_clk, // Media receive clock
  input wire logic [1:0] mode_pin, // Operating mode select
  input wire logic tx_en, // Transmit enable from the MAC
  input wire logic [3:0] txd, // Transmit nibble, bit 0 only in serial mode
  input wire logic media_rx_act, // Activity on the media input pair
  input wire logic [3:0] media_rx_data, // Decoded receive data from the media
  output logic tx_clk, // Transmit clock to the MAC
  output logic rx_clk, // Receive clock to the MAC
  output logic [3:0] rxd, // Receive data to the MAC
  output logic rx_dv, // Receive data valid
  output logic crs, // Carrier sense
  output logic col, // Collision and heartbeat
  output logic media_tx_en, // Media output pair active
  output logic [3:0] media_tx_data, // Media output data
  output logic media_tx_start, // Start code group leaves now
  output logic media_tx_end, // End code group leaves now
  output logic jabber // Jabber condition
);
  import pmlt_pkg::*;

  localparam int NPIN = 11;

  logic [1:0] rst_sync_reg;
  logic rst_n;
  logic [1:0] line_rst_reg;
  logic line_rst_n;
  logic [NPIN-1:0] pin_raw;
  logic [NPIN-1:0] pin_m_reg;
  logic [NPIN-1:0] pin_s_reg;
  pmlt_mode_e mode_r;
  logic mode10;
  logic tx_en_s;
  logic [3:0] txd_s;
  logic [3:0] rxd_s;
  logic act_m_reg;
  logic act_s_reg;
  logic [1:0] qual_cnt_reg;
  logic carrier_line_reg;
  logic car_m_reg;
  logic carrier_s_reg;
  logic [4:0] tx_hi, tx_lo, rx_hi, rx_lo;
  logic [4:0] tx_sel, rx_sel;
  logic [5:0] on_cyc, off_cyc;
  logic tx_rise_next, tx_fall_next, rx_fall_next;
  logic samp;
  logic tx_en_q_reg;
  logic [3:0] txd_q_reg;
  logic start_comb, end_comb;
  logic [6:0] tx_din, tx_tap;
  logic [4:0] rx_tap;
  pmlt_rx_e rx_st_reg;
  logic [5:0] rx_cnt_reg;
  logic crs_reg;
  pmlt_hb_e hb_st_reg;
  logic [5:0] hb_cnt_reg;
  logic col_reg;
  logic jab_reg;
  logic [23:0] jab_cnt_reg;

  // Reset release through two flip-flops in each domain
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_sync_reg <= 2'h0;
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_reg[1];

  always_ff @(posedge line_clk or negedge rst_b) begin
    if (!rst_b) begin
      line_rst_reg <= 2'h0;
    end else begin
      line_rst_reg <= {line_rst_reg[0], 1'b1};
    end
  end
  assign line_rst_n = line_rst_reg[1];

  // Pin synchronisers into the system clock domain
  assign pin_raw = {mode_pin, tx_en, txd, media_rx_data};
  genvar g;
  generate
    for (g = 0; g < NPIN; g++) begin : g_pin
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          pin_m_reg[g] <= 1'b0;
          pin_s_reg[g] <= 1'b0;
        end else begin
          pin_m_reg[g] <= pin_raw[g];
          pin_s_reg[g] <= pin_m_reg[g];
        end
      end
    end
  endgenerate

  assign tx_en_s = pin_s_reg[8];
  assign txd_s = pin_s_reg[7:4];
  assign rxd_s = pin_s_reg[3:0];

  // Unused mode code falls back to 100 Mb/s
  always_comb begin
    unique case (pin_s_reg[10:9])
      2'b01: mode_r = PMLT_M10MII;
      2'b10: mode_r = PMLT_M10SER;
      default: mode_r = PMLT_M100;
    endcase
  end
  assign mode10 = (mode_r != PMLT_M100);

  // Media activity is qualified on the link clock, then crossed as a level
  always_ff @(posedge line_clk or negedge line_rst_n) begin
    if (!line_rst_n) begin
      act_m_reg <= 1'b0;
      act_s_reg <= 1'b0;
      qual_cnt_reg <= 2'h0;
      carrier_line_reg <= 1'b0;
    end else begin
      act_m_reg <= media_rx_act;
      act_s_reg <= act_m_reg;
      if (act_s_reg == carrier_line_reg) begin
        qual_cnt_reg <= 2'h0;
      end else if (qual_cnt_reg == 2'(PMLT_LINE_QUAL_CYC - 1)) begin
        qual_cnt_reg <= 2'h0;
        carrier_line_reg <= act_s_reg;
      end else begin
        qual_cnt_reg <= qual_cnt_reg + 2'h1;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      car_m_reg <= 1'b0;
      carrier_s_reg <= 1'b0;
    end else begin
      car_m_reg <= carrier_line_reg;
      carrier_s_reg <= car_m_reg;
    end
  end

  // Per-mode clock phases and latencies
  always_comb begin
    unique case (mode_r)
      PMLT_M10MII: begin
        tx_hi = 5'(PMLT_TXCLK10_CYC);
        tx_lo = 5'(PMLT_TXCLK10_CYC);
        rx_hi = 5'(PMLT_RXCLK10_CYC);
        rx_lo = 5'(PMLT_RXCLK10_CYC);
        tx_sel = 5'(PMLT_TX10_LAT_CYC - 1);
        rx_sel = 5'(PMLT_RXDV10_CYC - 1);
        on_cyc = 6'(PMLT_CRS_ON10_CYC);
        off_cyc = 6'(PMLT_CRS_OFF10_LD_CYC);
      end
      PMLT_M10SER: begin
        tx_hi = 5'(PMLT_TXSER_HI_CYC);
        tx_lo = 5'(PMLT_TXSER_LO_CYC);
        rx_hi = 5'(PMLT_RXSER_CYC);
        rx_lo = 5'(PMLT_RXSER_CYC);
        tx_sel = 5'(PMLT_TX10_LAT_CYC - 1);
        rx_sel = 5'(PMLT_RXDV10_CYC - 1);
        on_cyc = 6'(PMLT_CRS_ON10_CYC);
        off_cyc = 6'(PMLT_CRS_OFF10_LD_CYC);
      end
      default: begin
        tx_hi = 5'(PMLT_TXCLK100_CYC);
        tx_lo = 5'(PMLT_TXCLK100_CYC);
        rx_hi = 5'(PMLT_TXCLK100_CYC);
        rx_lo = 5'(PMLT_TXCLK100_CYC);
        tx_sel = 5'(PMLT_TX100_LAT_CYC - 1);
        rx_sel = 5'(PMLT_RX100_LAT_CYC - 1);
        on_cyc = 6'(PMLT_CRS_ON100_CYC);
        off_cyc = 6'(PMLT_CRS_OFF100_CYC);
      end
    endcase
  end

  pmlt_clkgen u_tx_clk (
    .clk(clk),
    .rst_n(rst_n),
    .hi_len(tx_hi),
    .lo_len(tx_lo),
    .clk_out(tx_clk),
    .rise_next(tx_rise_next),
    .fall_next(tx_fall_next)
  );

  pmlt_clkgen u_rx_clk (
    .clk(clk),
    .rst_n(rst_n),
    .hi_len(rx_hi),
    .lo_len(rx_lo),
    .clk_out(rx_clk),
    .rise_next(),
    .fall_next(rx_fall_next)
  );

  // MII 10 Mb/s samples half a period after the MAC launches on the rise
  assign samp = (mode_r == PMLT_M10MII) ? tx_fall_next : tx_rise_next;
  assign start_comb = samp && tx_en_s && !tx_en_q_reg;
  assign end_comb = samp && !tx_en_s && tx_en_q_reg;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_en_q_reg <= 1'b0;
      txd_q_reg <= 4'h0;
    end else if (samp) begin
      tx_en_q_reg <= tx_en_s;
      txd_q_reg <= (mode_r == PMLT_M10SER) ? {3'h0, txd_s[0]} : txd_s;
    end
  end

  always_comb begin
    tx_din = {start_comb, end_comb, tx_en_q_reg, txd_q_reg};
    if (samp) begin
      tx_din[4] = tx_en_s;
      tx_din[3:0] = (mode_r == PMLT_M10SER) ? {3'h0, txd_s[0]} : txd_s;
    end
  end

  pmlt_delay #(.WIDTH(7), .DEPTH(PMLT_DLY_DEPTH)) u_tx_dly (
    .clk(clk),
    .rst_n(rst_n),
    .sel(tx_sel),
    .din(tx_din),
    .dout(tx_tap)
  );

  // Media output registers; jabber blanks the pair but not the code markers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      media_tx_start <= 1'b0;
      media_tx_end <= 1'b0;
      media_tx_en <= 1'b0;
      media_tx_data <= 4'h0;
    end else begin
      media_tx_start <= tx_tap[6];
      media_tx_end <= tx_tap[5];
      media_tx_en <= tx_tap[4] && !jab_reg;
      media_tx_data <= jab_reg ? 4'h0 : tx_tap[3:0];
    end
  end

  // Receive path: carrier and data travel together through one delay line
  pmlt_delay #(.WIDTH(5), .DEPTH(PMLT_DLY_DEPTH)) u_rx_dly (
    .clk(clk),
    .rst_n(rst_n),
    .sel(rx_sel),
    .din({carrier_s_reg, rxd_s}),
    .dout(rx_tap)
  );

  // Outputs move only as RX_CLK falls, leaving a full high phase of margin
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_dv <= 1'b0;
      rxd <= 4'h0;
    end else if (rx_fall_next) begin
      rx_dv <= rx_tap[4];
      rxd <= (mode_r == PMLT_M10SER) ? {3'h0, rx_tap[0]} : rx_tap[3:0];
    end
  end

  // Carrier sense: counters are loaded two short so the delay from the
  // crossed carrier edge to crs is exactly on_cyc or off_cyc
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_st_reg <= PMLT_RX_IDLE;
      rx_cnt_reg <= 6'h00;
      crs_reg <= 1'b0;
    end else begin
      unique case (rx_st_reg)
        PMLT_RX_IDLE: begin
          if (carrier_s_reg) begin
            rx_st_reg <= PMLT_RX_ON;
            rx_cnt_reg <= on_cyc - 6'h02;
          end
        end
        PMLT_RX_ON: begin
          if (!carrier_s_reg) begin
            rx_st_reg <= PMLT_RX_IDLE;
          end else if (rx_cnt_reg == 6'h00) begin
            rx_st_reg <= PMLT_RX_ACT;
            crs_reg <= 1'b1;
          end else begin
            rx_cnt_reg <= rx_cnt_reg - 6'h01;
          end
        end
        PMLT_RX_ACT: begin
          if (!carrier_s_reg) begin
            rx_st_reg <= PMLT_RX_OFF;
            rx_cnt_reg <= off_cyc - 6'h02;
          end
        end
        PMLT_RX_OFF: begin
          if (carrier_s_reg) begin
            rx_st_reg <= PMLT_RX_ACT;
          end else if (rx_cnt_reg == 6'h00) begin
            rx_st_reg <= PMLT_RX_IDLE;
            crs_reg <= 1'b0;
          end else begin
            rx_cnt_reg <= rx_cnt_reg - 6'h01;
          end
        end
      endcase
    end
  end
  assign crs = crs_reg;

  // Heartbeat after each 10 Mb/s transmission that ends while no heartbeat is pending or being sent
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hb_st_reg <= PMLT_HB_IDLE;
      hb_cnt_reg <= 6'h00;
    end else begin
      unique case (hb_st_reg)
        PMLT_HB_WAIT: begin
          if (hb_cnt_reg == 6'h00) begin
            hb_st_reg <= PMLT_HB_ON;
            hb_cnt_reg <= 6'(PMLT_HB_ON_CYC - 1);
          end else begin
            hb_cnt_reg <= hb_cnt_reg - 6'h01;
          end
        end
        PMLT_HB_ON: begin
          if (hb_cnt_reg == 6'h00) begin
            hb_st_reg <= PMLT_HB_IDLE;
          end else begin
            hb_cnt_reg <= hb_cnt_reg - 6'h01;
          end
        end
        default: begin
          if (end_comb && mode10) begin
            hb_st_reg <= PMLT_HB_WAIT;
            hb_cnt_reg <= 6'(PMLT_HB_DLY_CYC - 2);
          end
        end
      endcase
    end
  end

  // Real collision is own transmission meeting receive carrier
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      col_reg <= 1'b0;
    end else begin
      col_reg <= (hb_st_reg == PMLT_HB_ON) || (tx_en_q_reg && crs_reg);
    end
  end
  assign col = col_reg;

  // Jabber: the release timer runs regardless of TX_EN
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      jab_reg <= 1'b0;
      jab_cnt_reg <= 24'h000000;
    end else if (jab_reg) begin
      if (jab_cnt_reg == 24'(JAB_OFF_CYC - 1)) begin
        jab_reg <= 1'b0;
        jab_cnt_reg <= 24'h000000;
      end else begin
        jab_cnt_reg <= jab_cnt_reg + 24'h000001;
      end
    end else if (tx_en_q_reg && mode10) begin
      if (jab_cnt_reg == 24'(JAB_ON_CYC - 1)) begin
        jab_reg <= 1'b1;
        jab_cnt_reg <= 24'h000000;
      end else begin
        jab_cnt_reg <= jab_cnt_reg + 24'h000001;
      end
    end else begin
      jab_cnt_reg <= 24'h000000;
    end
  end
  assign jabber = jab_reg;

  localparam int A_TX100 = PMLT_TX100_LAT_CYC + 1; // Output register is seen one edge later
  localparam int A_TX10 = PMLT_TX10_LAT_CYC + 1;
  localparam int A_ON100 = PMLT_CRS_ON100_CYC;
  localparam int A_ON100P1 = PMLT_CRS_ON100_CYC + 1;
  localparam int A_ON10 = PMLT_CRS_ON10_CYC;
  localparam int A_ON10P1 = PMLT_CRS_ON10_CYC + 1;
  localparam int A_OFF100 = PMLT_CRS_OFF100_CYC;
  localparam int A_OFF100P1 = PMLT_CRS_OFF100_CYC + 1;
  localparam int A_OFF10 = PMLT_CRS_OFF10_LD_CYC;
  localparam int A_OFF10P1 = PMLT_CRS_OFF10_LD_CYC + 1;
  localparam int A_HB_DLY = PMLT_HB_DLY_CYC;
  localparam int A_HB_ON_M1 = PMLT_HB_ON_CYC - 1;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence s_tx_start_100;
    start_comb && mode_r == PMLT_M100;
  endsequence
  sequence s_tx_end_10;
    end_comb && mode10 && hb_st_reg == PMLT_HB_IDLE;
  endsequence
  sequence s_hb_pulse;
    ##A_HB_ON_M1 (hb_st_reg == PMLT_HB_ON) ##1 (hb_st_reg == PMLT_HB_IDLE);
  endsequence

  chk_tx_start_lat: assert property (s_tx_start_100 |-> ##A_TX100 media_tx_start)
    else $error("start code not at 100 Mb/s latency");
  chk_tx_end_lat: assert property ((end_comb && mode_r == PMLT_M100) |-> ##A_TX100 media_tx_end)
    else $error("end code not at 100 Mb/s latency");
  chk_crs_on_100: assert property ((mode_r == PMLT_M100 && $rose(crs_reg)) |->
      $past(carrier_s_reg, A_ON100) && !$past(carrier_s_reg, A_ON100P1))
    else $error("carrier sense on delay wrong at 100 Mb/s");
  chk_crs_off_100: assert property ((mode_r == PMLT_M100 && $fell(crs_reg)) |->
      !$past(carrier_s_reg, A_OFF100) && $past(carrier_s_reg, A_OFF100P1))
    else $error("carrier sense off delay wrong at 100 Mb/s");
  chk_mii_clk_phase: assert property ((mode_r == PMLT_M10MII && $rose(tx_clk)) |->
      tx_clk [*5] ##1 !tx_clk)
    else $error("10 Mb/s MII transmit clock phase wrong");
  chk_tx_lat_10: assert property ((start_comb && mode10 && !jab_reg) |-> ##A_TX10 media_tx_en)
    else $error("10 Mb/s transmit latency wrong");
  chk_ser_clk_phase: assert property ((mode_r == PMLT_M10SER && $rose(tx_clk)) |->
      ##1 !tx_clk [*2] ##1 tx_clk)
    else $error("serial transmit clock phase wrong");
  chk_rx_out_edge: assert property ((!$stable(rxd) || !$stable(rx_dv)) |-> $fell(rx_clk))
    else $error("receive outputs moved off the RX_CLK fall");
  chk_crs_on_10: assert property ((mode10 && $rose(crs_reg)) |->
      $past(carrier_s_reg, A_ON10) && !$past(carrier_s_reg, A_ON10P1))
    else $error("carrier sense on delay wrong at 10 Mb/s");
  chk_crs_off_10: assert property ((mode10 && $fell(crs_reg)) |->
      !$past(carrier_s_reg, A_OFF10) && $past(carrier_s_reg, A_OFF10P1))
    else $error("carrier sense off delay wrong at 10 Mb/s");
  chk_hb_timing: assert property (s_tx_end_10 |-> ##A_HB_DLY ((hb_st_reg == PMLT_HB_ON) ##0 s_hb_pulse))
    else $error("heartbeat delay or length wrong");
  chk_jab_release: assert property ($fell(jab_reg) |-> $past(jab_cnt_reg) == 24'(JAB_OFF_CYC - 1))
    else $error("jabber released early");
  chk_rx_clk_min: assert property (($past(mode_r) == PMLT_M10MII && $changed(rx_clk)) |=>
      $stable(rx_clk) [*4])
    else $error("receive clock phase too short");
  chk_jab_block: assert property ($past(jab_reg) |-> !media_tx_en)
    else $error("media driven during jabber");
endmodule // pmlt_top

/* verif/pmlt_mac_model.sv */
// MAC model that launches transmit inputs on the transmit clock rise
`timescale 1ns/1ps
module pmlt_mac_model (
  input wire logic clk, // System clock
  input wire logic tx_clk, // Transmit clock from the block
  input wire logic go, // Frame request from the bench
  output logic tx_en, // Transmit enable
  output logic [3:0] txd // Transmit nibble
);
  logic seen_hi;
  initial begin
    tx_en = 1'h0;
    txd = 4'h0;
    seen_hi = 1'h0;
  end
  // Idle data is inverted so a stale nibble never looks valid
  always @(negedge clk) begin
    if (tx_clk && !seen_hi) begin
      tx_en <= go;
      txd <= go ? txd + 4'h1 : ~txd;
    end
    seen_hi <= tx_clk;
  end
endmodule // pmlt_mac_model

/* verif/tb.sv */
// Self-checking bench for the MAC-side timing core
`timescale 1ns/1ps
module tb;
  logic clk, line_clk, rst_b, go, tx_en, media_rx_act, tx_clk, rx_clk, rx_dv, crs, col;
  logic media_tx_en, media_tx_start, media_tx_end, jabber;
  logic [1:0] mode_pin;
  logic [3:0] txd, media_rx_data, rxd, media_tx_data, first_nib;
  logic [9:0] obs;
  int num_errors, total_checks, n;
  assign obs = {rx_dv, media_tx_en, tx_en, rx_clk, tx_clk, media_tx_end, media_tx_start, jabber, col, crs};
  pmlt_top #(.JAB_ON_CYC(40), .JAB_OFF_CYC(60)) u_dut (.clk(clk), .rst_b(rst_b), .line_clk(line_clk),
    .mode_pin(mode_pin), .tx_en(tx_en), .txd(txd), .media_rx_act(media_rx_act), .media_rx_data(media_rx_data),
    .tx_clk(tx_clk), .rx_clk(rx_clk), .rxd(rxd), .rx_dv(rx_dv), .crs(crs), .col(col), .media_tx_en(media_tx_en),
    .media_tx_data(media_tx_data), .media_tx_start(media_tx_start), .media_tx_end(media_tx_end), .jabber(jabber));
  pmlt_mac_model u_mac (.clk(clk), .tx_clk(tx_clk), .go(go), .tx_en(tx_en), .txd(txd));
  initial begin
    clk = 1'h0;
    forever #20 clk = ~clk;
  end
  initial begin
    line_clk = 1'h0;
    #7;
    forever #7.5 line_clk = ~line_clk;
  end
  task automatic complete_run();
    $display("errors %0d checks %0d", num_errors, total_checks);
    if (num_errors == 0 && total_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic wait_lvl(input int w, input logic v, input int lim);
    n = 0;
    while (obs[w] !== v && n < lim) begin
      @(negedge clk);
      n++;
    end
    if (obs[w] !== v) begin
      num_errors++;
      $display("[ERR] %0t wait on signal %0d timed out", $time, w);
      complete_run();
    end
  endtask
  task automatic restart(input logic [1:0] m, input int len);
    rst_b = 1'h0;
    mode_pin = m;
    go <= 1'h0;
    media_rx_act = 1'h0;
    repeat (len) @(negedge clk);
    rst_b = 1'h1;
    repeat (8) @(negedge clk);
  endtask
  task automatic clk_phases(input logic [1:0] m, input int thi, input int tlo, input int rhi);
    restart(m, 5);
    for (int k = 5; k <= 6; k++) begin
      wait_lvl(k, 1'h0, 20);
      wait_lvl(k, 1'h1, 20);
      wait_lvl(k, 1'h0, 20);
      check(n, k == 5 ? thi : rhi);
      wait_lvl(k, 1'h1, 20);
      check(n, k == 5 ? tlo : rhi);
    end
  endtask
  task automatic tx_frame(input logic [1:0] m);
    restart(m, 5);
    go <= 1'h1;
    wait_lvl(7, 1'h1, 20);
    first_nib = (m == 2'h2) ? {3'h0, txd[0]} : txd;
    wait_lvl(5, 1'h0, 20);
    if (m == 2'h2) begin
      wait_lvl(5, 1'h1, 20);
    end
    wait_lvl(3, 1'h1, 20);
    check(m == 2'h0 ? n <= 4 : n, m == 2'h0 ? 1 : 8);
    check(media_tx_en, 1'h1);
    check(media_tx_data, first_nib);
    repeat (12) @(negedge clk);
    go <= 1'h0;
    wait_lvl(4, 1'h1, 60);
    check(media_tx_en, 1'h0);
    if (m != 2'h0) begin
      wait_lvl(1, 1'h1, 40);
      check(n, 22);
      wait_lvl(1, 1'h0, 40);
      check(n, 25);
    end
  endtask
  task automatic jabber_run();
    restart(2'h1, 5);
    go <= 1'h1;
    wait_lvl(2, 1'h1, 80);
    @(negedge clk);
    check(media_tx_en, 1'h0);
    check(media_tx_data, 4'h0);
    wait_lvl(2, 1'h0, 80);
    check(n, 59);
    wait_lvl(8, 1'h1, 15);
  endtask
  // Limits include a few cycles spent in the activity synchronisers
  task automatic rx_frame(input logic [1:0] m, input int on_max, input int off_max, input logic [3:0] exp);
    restart(m, 5);
    media_rx_act = 1'h1;
    wait_lvl(0, 1'h1, 40);
    check(n <= on_max, 1'h1);
    wait_lvl(9, 1'h1, 60);
    check(rxd, exp);
    media_rx_act = 1'h0;
    wait_lvl(0, 1'h0, 40);
    check(n <= off_max, 1'h1);
    wait_lvl(9, 1'h0, 60);
  endtask
  initial begin
    num_errors = 0;
    total_checks = 0;
    media_rx_data = 4'h5;
    restart(2'h0, 20);
    clk_phases(2'h0, 1, 1, 1);
    clk_phases(2'h1, 5, 5, 5);
    clk_phases(2'h2, 1, 2, 1);
    tx_frame(2'h0);
    tx_frame(2'h1);
    tx_frame(2'h2);
    jabber_run();
    rx_frame(2'h0, 12, 12, 4'h5);
    rx_frame(2'h1, 25, 25, 4'h5);
    rx_frame(2'h2, 25, 25, 4'h1);
    complete_run();
  end
endmodule // tb
